// file: src/olcc_pkg.sv
// Package: offsets, reset values, timing and carriers for the channel regs
package olcc_pkg;

    localparam int unsigned NCH = 8;

    // Register offsets
    localparam logic [7:0] OFS_RLB_EN  = 8'h02;
    localparam logic [7:0] OFS_ONES_TX = 8'h03;
    localparam logic [7:0] OFS_SA_STAT = 8'h04;
    localparam logic [7:0] OFS_DF_STAT = 8'h05;
    localparam logic [7:0] OFS_SA_IEN  = 8'h06;
    localparam logic [7:0] OFS_DF_IEN  = 8'h07;
    localparam logic [7:0] OFS_SA_IFL  = 8'h08;
    localparam logic [7:0] OFS_DF_IFL  = 8'h09;
    localparam logic [7:0] OFS_SRST    = 8'h0A;
    localparam logic [7:0] OFS_MON     = 8'h0B;
    localparam logic [7:0] OFS_DLB_EN  = 8'h0C;
    localparam logic [7:0] OFS_CRIT    = 8'h0D;
    localparam logic [7:0] OFS_AUTO1   = 8'h0E;

    // Reset values
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_SRST = 8'hFF;

    // Monitor select field
    localparam int unsigned MON_SEL_LSB = 0;
    localparam int unsigned MON_SEL_W   = 4;
    localparam int unsigned MON_TX_BIT  = 3;

    // Soft reset pulse: 1 us at 100 MHz
    localparam int unsigned SRST_NS    = 1000;
    localparam int unsigned CLK_NS     = 10;
    localparam int unsigned SRST_CYC   = SRST_NS / CLK_NS;
    localparam int unsigned SRST_CNT_W = 8;

    // Host access request
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } olcc_req_s;

    // Monitor routing result
    typedef struct packed {
        logic       valid;
        logic       is_tx;
        logic [2:0] chan;
    } olcc_mon_s;

    typedef enum logic [0:0] {
        OLCC_RUN  = 1'b0,
        OLCC_SRST = 1'b1
    } olcc_state_e;

endpackage

// file: src/olcc_regs.sv
// Per-channel control and status register bank for an octal line interface
`timescale 1ns/1ps
// How it works
// - Remote loopback enable at 02, one bit per channel, resets to zero.
// - All-ones transmit at 03, defaults zero; set bit sends all ones.
// - Read-only signal-absent status at 04, one while loss detected.
// - Read-only driver-fault status at 05, one while driver fault seen.
// - Driver faults reported only in T1 mode without series resistors.
// - Signal-absent interrupt enable at 06, set bit permits interrupts.
// - Driver-fault interrupt enable at 07, set bit permits interrupts.
// - Signal-absent flags at 08 set on status change of an enabled channel, clear on 04 read.
// - Driver-fault flags at 09 set on status change of an enabled channel, clear on 05 read.
// - A write to 0A while no reset runs starts a 1 us reset of all registers.
// - Soft reset register content stays FF whatever is written.
// - Monitor select 0000 and 1000 mean no monitoring.
// - Select 0001 to 0111 monitors receiver of that number.
// - Select 1001 to 1111 monitors transmitter of value minus eight.
// - Digital loopback enable at 0C, defaults zero.
// - In E1 mode criteria bit picks G.775 (0) or ETSI 300233 (1).
// - In T1 mode the T1.231 loss criterion always applies.
// - Auto all-ones at 0E sends all ones while signal absent.
module olcc_regs #(
    parameter int unsigned NCH = olcc_pkg::NCH
) (
    // Clock and reset
    input  wire logic             ref_clk_i,
    input  wire logic             resetn_i,
    // Host register port
    input  wire logic             host_wr_i,
    input  wire logic             host_rd_i,
    input  wire logic [7:0]       host_addr_i,
    input  wire logic [7:0]       host_wdata_i,
    output logic      [7:0]       host_rdata_o,
    // Line-side status from channels (asynchronous)
    input  wire logic [NCH-1:0]   sig_absent_i,
    input  wire logic [NCH-1:0]   drv_fault_i,
    input  wire logic             t1_mode_i,
    input  wire logic             no_series_res_i,
    // Channel controls
    output logic      [NCH-1:0]   remote_loopback_o,
    output logic      [NCH-1:0]   digital_loopback_o,
    output logic      [NCH-1:0]   ones_tx_o,
    output logic      [NCH-1:0]   etsi_crit_o,
    output logic      [2:0]       monitor_chan_o,
    output logic                  monitor_tx_o,
    output logic                  monitor_en_o,
    output logic                  soft_reset_o,
    output logic                  irq_o
);

    // ==========================================================
    // Input synchronisers
    logic [NCH-1:0] sa_m_q, sa_s_q, df_m_q, df_s_q;
    logic [1:0]     md_m_q, md_s_q;

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sa_m_q <= '0;
            sa_s_q <= '0;
        end else begin
            sa_m_q <= sig_absent_i;
            sa_s_q <= sa_m_q;
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            df_m_q <= '0;
            df_s_q <= '0;
        end else begin
            df_m_q <= drv_fault_i;
            df_s_q <= df_m_q;
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            md_m_q <= '0;
            md_s_q <= '0;
        end else begin
            md_m_q <= {t1_mode_i, no_series_res_i};
            md_s_q <= md_m_q;
        end
    end

    // ==========================================================
    // Host request decode
    olcc_pkg::olcc_req_s req;
    assign req = '{wr: host_wr_i, rd: host_rd_i,
                   addr: host_addr_i, wdata: host_wdata_i};

    function automatic logic hit(input olcc_pkg::olcc_req_s r,
                                 input logic [7:0] ofs);
        hit = r.addr == ofs;
    endfunction

    wire wr_rlb   = req.wr && hit(req, olcc_pkg::OFS_RLB_EN);
    wire wr_ones  = req.wr && hit(req, olcc_pkg::OFS_ONES_TX);
    wire wr_saien = req.wr && hit(req, olcc_pkg::OFS_SA_IEN);
    wire wr_dfien = req.wr && hit(req, olcc_pkg::OFS_DF_IEN);
    wire wr_srst  = req.wr && hit(req, olcc_pkg::OFS_SRST);
    wire wr_mon   = req.wr && hit(req, olcc_pkg::OFS_MON);
    wire wr_dlb   = req.wr && hit(req, olcc_pkg::OFS_DLB_EN);
    wire wr_crit  = req.wr && hit(req, olcc_pkg::OFS_CRIT);
    wire wr_auto  = req.wr && hit(req, olcc_pkg::OFS_AUTO1);
    wire rd_sa    = req.rd && hit(req, olcc_pkg::OFS_SA_STAT);
    wire rd_df    = req.rd && hit(req, olcc_pkg::OFS_DF_STAT);

    // ==========================================================
    // Soft reset sequencer
    olcc_pkg::olcc_state_e st_q, st_d;
    logic [olcc_pkg::SRST_CNT_W-1:0] cnt_q, cnt_d;
    localparam logic [olcc_pkg::SRST_CNT_W-1:0] SRST_LAST =
        olcc_pkg::SRST_CNT_W'(olcc_pkg::SRST_CYC - 1);

    always_comb begin
        st_d  = st_q;
        cnt_d = cnt_q;
        case (st_q)
            olcc_pkg::OLCC_RUN: begin
                if (wr_srst) begin
                    st_d  = olcc_pkg::OLCC_SRST;
                    cnt_d = '0;
                end
            end
            olcc_pkg::OLCC_SRST: begin
                // Writes during the pulse are absorbed; pulse is not re-armed
                if (cnt_q == SRST_LAST) begin
                    st_d = olcc_pkg::OLCC_RUN;
                end else begin
                    cnt_d = cnt_q + 1'b1;
                end
            end
            default: begin
                st_d = olcc_pkg::OLCC_RUN;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_q  <= olcc_pkg::OLCC_RUN;
            cnt_q <= '0;
        end else begin
            st_q  <= st_d;
            cnt_q <= cnt_d;
        end
    end

    wire srst = (st_q == olcc_pkg::OLCC_SRST);

    // ==========================================================
    // Control registers
    logic [NCH-1:0] rlb_q, ones_q, saien_q, dfien_q, dlb_q, crit_q, auto_q;
    logic [7:0]     mon_q;
    // Readback of the trigger register is a constant
    wire  [7:0]     srst_val = olcc_pkg::RST_SRST;

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rlb_q <= '0;
        end else if (srst) begin
            rlb_q <= '0;
        end else if (wr_rlb) begin
            rlb_q <= req.wdata[NCH-1:0];
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ones_q <= '0;
        end else if (srst) begin
            ones_q <= '0;
        end else if (wr_ones) begin
            ones_q <= req.wdata[NCH-1:0];
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            saien_q <= '0;
        end else if (srst) begin
            saien_q <= '0;
        end else if (wr_saien) begin
            saien_q <= req.wdata[NCH-1:0];
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            dfien_q <= '0;
        end else if (srst) begin
            dfien_q <= '0;
        end else if (wr_dfien) begin
            dfien_q <= req.wdata[NCH-1:0];
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            dlb_q <= '0;
        end else if (srst) begin
            dlb_q <= '0;
        end else if (wr_dlb) begin
            dlb_q <= req.wdata[NCH-1:0];
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            crit_q <= '0;
        end else if (srst) begin
            crit_q <= '0;
        end else if (wr_crit) begin
            crit_q <= req.wdata[NCH-1:0];
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            auto_q <= '0;
        end else if (srst) begin
            auto_q <= '0;
        end else if (wr_auto) begin
            auto_q <= req.wdata[NCH-1:0];
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            mon_q <= olcc_pkg::RST_ZERO;
        end else if (srst) begin
            mon_q <= olcc_pkg::RST_ZERO;
        end else if (wr_mon) begin
            mon_q <= req.wdata;
        end
    end

    // ==========================================================
    // Status, change detection and sticky flags
    wire df_valid = md_s_q[1] & md_s_q[0];
    logic [NCH-1:0] sa_st_q, df_st_q, sa_fl_q, df_fl_q;
    wire  [NCH-1:0] df_live = df_valid ? df_s_q : '0;
    // Status is held at zero during soft reset so no false change
    wire  [NCH-1:0] sa_next = srst ? '0 : sa_s_q;
    wire  [NCH-1:0] df_next = srst ? '0 : df_live;
    wire  [NCH-1:0] sa_chg  = (sa_next ^ sa_st_q) & saien_q;
    wire  [NCH-1:0] df_chg  = (df_next ^ df_st_q) & dfien_q;

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sa_st_q <= '0;
            df_st_q <= '0;
            sa_fl_q <= '0;
            df_fl_q <= '0;
        end else begin
            sa_st_q <= sa_next;
            df_st_q <= df_next;
            if (srst) begin
                sa_fl_q <= '0;
                df_fl_q <= '0;
            end else begin
                // A change in the read cycle survives the clear
                sa_fl_q <= (rd_sa ? '0 : sa_fl_q) | sa_chg;
                df_fl_q <= (rd_df ? '0 : df_fl_q) | df_chg;
            end
        end
    end

    // ==========================================================
    // Monitor point decode
    wire [3:0] msel = mon_q[olcc_pkg::MON_SEL_LSB +: olcc_pkg::MON_SEL_W];
    olcc_pkg::olcc_mon_s mon;
    // Upper four bits are reserved and left to the host to keep clear
    assign mon.is_tx = msel[olcc_pkg::MON_TX_BIT];
    assign mon.chan  = msel[2:0];
    assign mon.valid = msel[2:0] != 3'h0;

    // ==========================================================
    // Read mux
    logic [7:0] rd_d;
    always_comb begin
        rd_d = 8'h00;
        case (host_addr_i)
            olcc_pkg::OFS_RLB_EN:  rd_d = 8'(rlb_q);
            olcc_pkg::OFS_ONES_TX: rd_d = 8'(ones_q);
            olcc_pkg::OFS_SA_STAT: rd_d = 8'(sa_st_q);
            olcc_pkg::OFS_DF_STAT: rd_d = 8'(df_st_q);
            olcc_pkg::OFS_SA_IEN:  rd_d = 8'(saien_q);
            olcc_pkg::OFS_DF_IEN:  rd_d = 8'(dfien_q);
            olcc_pkg::OFS_SA_IFL:  rd_d = 8'(sa_fl_q);
            olcc_pkg::OFS_DF_IFL:  rd_d = 8'(df_fl_q);
            olcc_pkg::OFS_SRST:    rd_d = srst_val;
            olcc_pkg::OFS_MON:     rd_d = mon_q;
            olcc_pkg::OFS_DLB_EN:  rd_d = 8'(dlb_q);
            olcc_pkg::OFS_CRIT:    rd_d = 8'(crit_q);
            olcc_pkg::OFS_AUTO1:   rd_d = 8'(auto_q);
            default:               rd_d = 8'h00;
        endcase
    end

    // ==========================================================
    // Registered outputs
    // Criteria bits ignored in T1 mode
    wire [NCH-1:0] crit_eff = md_s_q[1] ? '0 : crit_q;
    wire [NCH-1:0] ones_eff = ones_q | (auto_q & sa_s_q);

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            host_rdata_o <= 8'h00;
        end else begin
            host_rdata_o <= rd_d;
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            remote_loopback_o  <= '0;
            digital_loopback_o <= '0;
            ones_tx_o          <= '0;
            etsi_crit_o        <= '0;
        end else begin
            remote_loopback_o  <= rlb_q;
            digital_loopback_o <= dlb_q;
            ones_tx_o          <= ones_eff;
            etsi_crit_o        <= crit_eff;
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            monitor_chan_o <= 3'h0;
            monitor_tx_o   <= 1'b0;
            monitor_en_o   <= 1'b0;
            soft_reset_o   <= 1'b0;
            irq_o          <= 1'b0;
        end else begin
            monitor_chan_o <= mon.valid ? mon.chan : 3'h0;
            monitor_tx_o   <= mon.valid & mon.is_tx;
            monitor_en_o   <= mon.valid;
            soft_reset_o   <= srst;
            irq_o          <= |{sa_fl_q, df_fl_q};
        end
    end

endmodule

// file: testbench/olcc_host_model.sv
// Host processor model: one-cycle strobed register accesses
`timescale 1ns/1ps
module olcc_host_model (
    // Clock and host port
    input  wire logic       ref_clk_i,
    output logic            host_wr_o,
    output logic            host_rd_o,
    output logic [7:0]      host_addr_o,
    output logic [7:0]      host_wdata_o,
    input  wire logic [7:0] host_rdata_i
);
    // Idle bus parks on an unmapped offset, data inverted, never last value
    initial begin
        host_wr_o = 1'b0;
        host_rd_o = 1'b0;
        host_addr_o = 8'h7F;
        host_wdata_o = 8'h00;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        #1;
        host_addr_o = a;
        host_wdata_o = d;
        host_wr_o = 1'b1;
        @(posedge ref_clk_i);
        #1;
        host_wr_o = 1'b0;
        host_addr_o = 8'h7F;
        host_wdata_o = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk_i);
        #1;
        host_addr_o = a;
        host_rd_o = 1'b1;
        @(posedge ref_clk_i);
        #1;
        d = host_rdata_i;
        host_rd_o = 1'b0;
        host_addr_o = 8'h7F;
    endtask
endmodule

// file: testbench/olcc_regs_checker.sv
// Port assertions for the channel register bank
`timescale 1ns/1ps
module olcc_chk #(
    parameter int unsigned NCH = 8
) (
    // Clock, reset and host port
    input wire logic           ref_clk_i,
    input wire logic           resetn_i,
    input wire logic           host_wr_i,
    input wire logic           host_rd_i,
    input wire logic [7:0]     host_addr_i,
    input wire logic [7:0]     host_wdata_i,
    input wire logic [7:0]     host_rdata_o,
    // Line status
    input wire logic [NCH-1:0] sig_absent_i,
    input wire logic [NCH-1:0] drv_fault_i,
    input wire logic           t1_mode_i,
    input wire logic           no_series_res_i,
    // Channel controls
    input wire logic [NCH-1:0] remote_loopback_o,
    input wire logic [NCH-1:0] digital_loopback_o,
    input wire logic [NCH-1:0] ones_tx_o,
    input wire logic [NCH-1:0] etsi_crit_o,
    input wire logic [2:0]     monitor_chan_o,
    input wire logic           monitor_tx_o,
    input wire logic           monitor_en_o,
    input wire logic           soft_reset_o,
    input wire logic           irq_o
);
    default clocking
        @(posedge ref_clk_i);
    endclocking
    default disable iff (!resetn_i);
    // =============================================
    // Helpers: the output flag lags the internal reset by a cycle,
    // so a fresh reset write also makes the bank unquiet
    logic [7:0] hi_q;
    logic [7:0] rd_q;
    logic       srst_wr_q;
    wire        quiet = !soft_reset_o && !srst_wr_q;
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            hi_q <= 8'h00;
            rd_q <= 8'h00;
            srst_wr_q <= 1'b0;
        end else begin
            hi_q <= soft_reset_o ? hi_q + 8'h01 : 8'h00;
            rd_q <= host_rdata_o;
            srst_wr_q <= host_wr_i && host_addr_i == 8'h0A;
        end
    end
    // =============================================
    // Properties
    property p_srst_go;
        host_wr_i && host_addr_i == 8'h0A && !soft_reset_o
            |-> ##[1:3] soft_reset_o;
    endproperty
    a_srst_go: assert property (p_srst_go)
        else $error("no soft reset");
    property p_srst_len;
        $fell(soft_reset_o) |-> hi_q == 8'h64;
    endproperty
    a_srst_len: assert property (p_srst_len)
        else $error("bad length");
    property p_srst_clr;
        $rose(soft_reset_o) |-> ##2 (remote_loopback_o == '0 && !irq_o
            && digital_loopback_o == '0 && ones_tx_o == '0 && !monitor_en_o);
    endproperty
    a_srst_clr: assert property (p_srst_clr)
        else $error("not cleared");
    property p_srst_rd;
        host_addr_i == 8'h0A |=> host_rdata_o == 8'hFF;
    endproperty
    a_srst_rd: assert property (p_srst_rd)
        else $error("reset reg read");
    property p_rlb;
        host_addr_i == 8'h02 && !host_wr_i && quiet
            |=> ##1 remote_loopback_o == rd_q;
    endproperty
    a_rlb: assert property (p_rlb)
        else $error("remote loop out");
    property p_dlb;
        host_addr_i == 8'h0C && !host_wr_i && quiet
            |=> ##1 digital_loopback_o == rd_q;
    endproperty
    a_dlb: assert property (p_dlb)
        else $error("digital loop out");
    property p_mon;
        host_addr_i == 8'h0B && !host_wr_i && quiet |=> ##1
            (monitor_en_o == (rd_q[2:0] != 3'h0) && monitor_chan_o == rd_q[2:0]
            && (!monitor_en_o || monitor_tx_o == rd_q[3]));
    endproperty
    a_mon: assert property (p_mon)
        else $error("monitor decode");
    property p_t1_crit;
        t1_mode_i [*5] |-> etsi_crit_o == '0;
    endproperty
    a_t1_crit: assert property (p_t1_crit)
        else $error("criteria in T1");
    property p_df_gate;
        !t1_mode_i [*5] ##0 host_addr_i == 8'h05 |=> host_rdata_o == 8'h00;
    endproperty
    a_df_gate: assert property (p_df_gate)
        else $error("fault in E1");
    c_srst: cover property ($rose(soft_reset_o));
    c_mon_tx: cover property (monitor_en_o && monitor_tx_o);
    c_irq: cover property ($rose(irq_o));
endmodule
bind olcc_regs olcc_chk #(.NCH(NCH)) u_chk (
    .ref_clk_i, .resetn_i, .host_wr_i, .host_rd_i, .host_addr_i,
    .host_wdata_i, .host_rdata_o, .sig_absent_i, .drv_fault_i,
    .t1_mode_i, .no_series_res_i, .remote_loopback_o,
    .digital_loopback_o, .ones_tx_o, .etsi_crit_o, .monitor_chan_o,
    .monitor_tx_o, .monitor_en_o, .soft_reset_o, .irq_o
);

// file: testbench/tb.sv
// Self-checking bench for the channel register bank
`timescale 1ns/1ps
module tb;
    logic       ref_clk_i, resetn_i, host_wr_i, host_rd_i;
    logic [7:0] host_addr_i, host_wdata_i, host_rdata_o;
    logic [7:0] sig_absent_i, drv_fault_i, remote_loopback_o;
    logic [7:0] digital_loopback_o, ones_tx_o, etsi_crit_o;
    logic       t1_mode_i, no_series_res_i, monitor_tx_o, monitor_en_o;
    logic       soft_reset_o, irq_o;
    logic [2:0] monitor_chan_o;
    wire  [7:0] mon_got = {2'h0, monitor_en_o, monitor_tx_o, 1'b0,
                           monitor_chan_o};
    int         bad_count, cmp_count, cyc, n;
    logic [7:0] rw [8] = '{8'h02, 8'h03, 8'h06, 8'h07,
                           8'h0B, 8'h0C, 8'h0D, 8'h0E};
    logic [7:0] ro [4] = '{8'h04, 8'h05, 8'h08, 8'h09};
    olcc_regs DUT (
        .ref_clk_i, .resetn_i, .host_wr_i, .host_rd_i, .host_addr_i,
        .host_wdata_i, .host_rdata_o, .sig_absent_i, .drv_fault_i,
        .t1_mode_i, .no_series_res_i, .remote_loopback_o,
        .digital_loopback_o, .ones_tx_o, .etsi_crit_o, .monitor_chan_o,
        .monitor_tx_o, .monitor_en_o, .soft_reset_o, .irq_o
    );
    olcc_host_model host (
        .ref_clk_i, .host_wr_o(host_wr_i), .host_rd_o(host_rd_i),
        .host_addr_o(host_addr_i), .host_wdata_o(host_wdata_i),
        .host_rdata_i(host_rdata_o)
    );
    initial begin
        ref_clk_i = 1'b0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end
    // =============================================
    // Checking helpers
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        host.rd(a, d);
        chk(d, e);
    endtask
    task automatic wait_cyc(input int k);
        repeat (k) @(posedge ref_clk_i);
        #1;
    endtask
    function automatic logic [7:0] val(input logic [7:0] a);
        return (a == 8'h0B) ? 8'h0D : (8'h5A ^ a);
    endfunction
    // Expected monitor outputs for a select value
    function automatic logic [7:0] mon_exp(input logic [3:0] s);
        logic act;
        act = s[2:0] != 3'h0;
        return {2'h0, act, act & s[3], 1'b0, act ? s[2:0] : 3'h0};
    endfunction
    task automatic results;
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Hang guard: the full sequence needs well under 2000 cycles
    always @(posedge ref_clk_i) begin
        cyc++;
        if (cyc == 6000) begin
            bad_count++;
            results();
        end
    end
    // =============================================
    // Tests
    initial begin
        resetn_i = 1'b0;
        sig_absent_i = 8'h00;
        drv_fault_i = 8'h00;
        t1_mode_i = 1'b0;
        no_series_res_i = 1'b0;
        wait_cyc(4);
        resetn_i = 1'b1;
        for (int a = 0; a < 16; a++)
            rchk(a[7:0], (a == 10) ? 8'hFF : 8'h00);
        $display("defaults done");
        foreach (rw[i]) host.wr(rw[i], val(rw[i]));
        foreach (ro[i]) host.wr(ro[i], 8'hFF);
        foreach (rw[i]) rchk(rw[i], val(rw[i]));
        foreach (ro[i]) rchk(ro[i], 8'h00);
        chk(remote_loopback_o, 8'h58);
        chk(digital_loopback_o, 8'h56);
        chk(ones_tx_o, 8'h59);
        chk(etsi_crit_o, 8'h57);
        chk(mon_got, 8'h35);
        t1_mode_i = 1'b1;
        wait_cyc(6);
        chk(etsi_crit_o, 8'h00);
        $display("read write done");
        for (int m = 0; m < 16; m++) begin
            host.wr(8'h0B, m[7:0]);
            wait_cyc(2);
            chk(mon_got, mon_exp(m[3:0]));
        end
        $display("monitor done");
        host.wr(8'h03, 8'h00);
        host.wr(8'h06, 8'h01);
        host.wr(8'h0E, 8'h03);
        sig_absent_i = 8'h03;
        wait_cyc(6);
        chk(ones_tx_o, 8'h03);
        chk({7'h00, irq_o}, 8'h01);
        rchk(8'h08, 8'h01);
        rchk(8'h04, 8'h03);
        rchk(8'h08, 8'h00);
        chk({7'h00, irq_o}, 8'h00);
        $display("signal loss done");
        host.wr(8'h07, 8'h80);
        drv_fault_i = 8'h80;
        wait_cyc(6);
        rchk(8'h05, 8'h00);
        no_series_res_i = 1'b1;
        wait_cyc(6);
        rchk(8'h09, 8'h80);
        rchk(8'h05, 8'h80);
        rchk(8'h09, 8'h00);
        $display("driver fault done");
        host.wr(8'h0A, 8'h00);
        n = 0;
        while (soft_reset_o !== 1'b1 && n < 8) begin
            wait_cyc(1);
            n++;
        end
        n = 0;
        while (soft_reset_o === 1'b1 && n < 200) begin
            wait_cyc(1);
            n++;
        end
        chk(n[7:0], 8'h64);
        rchk(8'h02, 8'h00);
        rchk(8'h0A, 8'hFF);
        chk(ones_tx_o, 8'h00);
        $display("soft reset done");
        results();
    end
endmodule
